// file: core/slrs_defs.vh
// Purpose: constants for the strap latch and ready status block
// Assumes: included by bare name
// Notes:   bit positions index the packed soft strap word
`ifndef SLRS_DEFS_VH
`define SLRS_DEFS_VH

`define SLRS_STRAP_W        16
`define SLRS_IND_EN_LSB     0
`define SLRS_IND_EN_MSB     2
`define SLRS_IND_FUN_LSB    3
`define SLRS_IND_FUN_MSB    5
`define SLRS_QUAL_BIT       6
`define SLRS_STYLE_BIT      7
`define SLRS_SEL_POL_BIT    8
`define SLRS_RD_POL_BIT     9
`define SLRS_WR_POL_BIT     10
`define SLRS_AS_POL_BIT     11
`define SLRS_TS_EN_BIT      12
`define SLRS_HARD_W         4
`define SLRS_IND_EN_DEF     3'h7
`define SLRS_IND_FUN_DEF    3'h0
`define SLRS_TS_EN_DEF      1'h0
`define SLRS_QUAL_DEF       1'h1
`define SLRS_STYLE_DEF      1'h0
`define SLRS_PIN_W          4
`define SLRS_PLL_SETTLE_NS  1000
`define SLRS_CLK_NS         25

`endif

// file: core/slrs_sync2.v
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are asynchronous to ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module slrs_sync2 #(
  parameter W = 1
) (
  // clock
  input  wire         ref_clk,
  // async level in, synchronised level out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q_ff
);
  reg [W-1:0] meta_ff;

  always @(posedge ref_clk) begin
    meta_ff <= d;
    q_ff    <= meta_ff;
  end
endmodule

// file: core/slrs_top.v
// Purpose: strap capture, soft strap override and device ready flag
// Assumes: loader and power manager are logic on ref_clk; strap pins are async
// Notes:   rst is the power-on or pin reset; digital reset is separate
//
// How it works
// RULE1 - ready shown in two status outputs
// RULE2 - ready rises only after loader finishes
// RULE3 - reload command restarts loader, ready low; code ignores it in load and sleep, or if full power drops that cycle
// RULE4 - mac reset runs loader, ready low; code ignores it in load and sleep, or if full power drops that cycle
// RULE5 - non full power state forces ready low
// RULE6 - wake: full power plus pll lock first
// RULE7 - straps latched at reset; hard never overridden
// RULE8 - soft straps sampled at release, then overridden
// RULE9 - pinless soft straps take built-in defaults
// RULE10 - absent memory restores last latched soft straps
// RULE11 - only reset resamples strap pins
// RULE12 - indicator enable strap sets reset value
// RULE13 - indicator function strap sets reset value
// RULE14 - address strobe qualify strap, default one
// RULE15 - access style strap selects strobe scheme
// RULE16 - select polarity strap sets chip select level
// RULE17 - read polarity strap sets read/direction sense
// RULE18 - write polarity strap sets write/enable level
// RULE19 - address strobe polarity strap, default one
// RULE20 - timestamp enable strap sets reset value
// RULE21 - host only reads few registers while not ready
// RULE22 - ready rising edge pulses ready event
// RULE23 - apply loader straps before raising ready
`timescale 1ns/10ps
`include "slrs_defs.vh"
module slrs_top #(
  parameter STRAP_W    = `SLRS_STRAP_W,
  parameter HARD_W     = `SLRS_HARD_W,
  parameter PIN_W      = `SLRS_PIN_W,
  parameter SETTLE_NS  = `SLRS_PLL_SETTLE_NS,
  parameter CLK_NS     = `SLRS_CLK_NS
) (
  // clock and power-on / pin reset
  input  wire               ref_clk,
  input  wire               rst,
  // strap pins (async levels)
  input  wire [HARD_W-1:0]  hard_strap_pins,
  input  wire [PIN_W-1:0]   soft_strap_pins,
  // reset and reload requests
  input  wire               digital_reset_req,
  input  wire               mac_reset_req,
  input  wire               reload_cmd,
  // loader handshake
  output reg                loader_start_ff,
  input  wire               loader_done,
  input  wire               mem_present,
  input  wire               loader_strap_valid,
  input  wire [STRAP_W-1:0] loader_strap_data,
  // power state
  input  wire               full_power_state,
  input  wire               pll_locked,
  // ready status
  output wire               pmc_ready,
  output wire               hwc_ready,
  output reg                ready_rise_ff,
  output wire               loader_busy,
  // captured hard straps
  output reg  [HARD_W-1:0]  hard_strap_ff,
  // strap-driven defaults
  output wire [2:0]         indicator_enable_bits,
  output wire [2:0]         indicator_function_bits,
  output wire               addr_strobe_qualify,
  output wire               access_style,
  output wire               select_polarity,
  output wire               read_polarity,
  output wire               write_polarity,
  output wire               addr_strobe_polarity,
  output wire               timestamp_enable
);
  // pll settle time rounds up to whole cycles
  localparam integer SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // wide enough for a settle of a few thousand cycles
  localparam integer CNT_W      = 12;

  // idle: ready, or waiting for capture
  // load: loader running, ready held low
  // sleep: low power state, ready held low
  // wake: settle count and pll lock before ready
  // every entry to wake passes through count zero and lock
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_LOAD  = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;
  localparam [1:0] ST_WAKE  = 2'h3;

  wire [HARD_W-1:0] hard_sync;
  wire [PIN_W-1:0]  soft_sync;

  // pins pass two flops before any logic reads them
  slrs_sync2 #(.W(HARD_W)) u_hard_sync (
    .ref_clk (ref_clk),
    .d       (hard_strap_pins),
    .q_ff    (hard_sync)
  );

  slrs_sync2 #(.W(PIN_W)) u_soft_sync (
    .ref_clk (ref_clk),
    .d       (soft_strap_pins),
    .q_ff    (soft_sync)
  );

  reg  [1:0]         state_ff;
  reg  [1:0]         nxt_state;
  reg                ready_ff;
  reg                nxt_ready;
  reg  [CNT_W-1:0]   cnt_ff;
  reg  [CNT_W-1:0]   nxt_cnt;
  reg                capture_ff;
  reg  [STRAP_W-1:0] latched_ff;
  reg  [STRAP_W-1:0] active_ff;
  reg  [STRAP_W-1:0] nxt_active;
  reg                got_mem_ff;
  reg                nxt_got_mem;
  reg                nxt_start;
  wire               restart;
  wire [STRAP_W-1:0] pin_word;

  // soft strap sources: one name per pin, plus tie-offs for the pinless straps
  wire               sel_pol_pin;
  wire               rd_pol_pin;
  wire               wr_pol_pin;
  wire               as_pol_pin;
  wire               ts_en_tie;
  wire               qual_tie;
  wire               style_tie;
  wire [2:0]         ind_en_tie;
  wire [2:0]         ind_fun_tie;

  assign sel_pol_pin = soft_sync[0];   // see RULE16
  assign rd_pol_pin  = soft_sync[1];   // see RULE17
  assign wr_pol_pin  = soft_sync[2];   // see RULE18
  assign as_pol_pin  = soft_sync[3];   // see RULE19

  // pinless soft straps carry tie-off defaults
  assign ts_en_tie   = `SLRS_TS_EN_DEF;     // see RULE9 RULE20
  assign qual_tie    = `SLRS_QUAL_DEF;      // see RULE14
  assign style_tie   = `SLRS_STYLE_DEF;     // see RULE15
  assign ind_en_tie  = `SLRS_IND_EN_DEF;    // see RULE12
  assign ind_fun_tie = `SLRS_IND_FUN_DEF;   // see RULE13

  assign pin_word = {{(STRAP_W-`SLRS_TS_EN_BIT-1){1'b0}},
                     ts_en_tie,
                     as_pol_pin,
                     wr_pol_pin,
                     rd_pol_pin,
                     sel_pol_pin,
                     style_tie,
                     qual_tie,
                     ind_fun_tie,
                     ind_en_tie};

  // any reload source starts the loader again without touching the pins
  wire               dig_restart;
  wire               mac_restart;
  wire               cmd_restart;
  assign dig_restart = digital_reset_req;                // see RULE11
  assign mac_restart = mac_reset_req;                    // see RULE4
  assign cmd_restart = reload_cmd;                       // see RULE3
  assign restart     = dig_restart | mac_restart | cmd_restart;

  // strap capture one edge after release so the synchronisers have settled
  always @(posedge ref_clk) begin
    if (rst) begin
      capture_ff    <= 1'b1;
      latched_ff    <= {STRAP_W{1'b0}};
      hard_strap_ff <= {HARD_W{1'b0}};
    end else begin
      capture_ff <= 1'b0;
      if (capture_ff) begin
        latched_ff    <= pin_word;                 // see RULE8 RULE11
        hard_strap_ff <= hard_sync;                // see RULE7
      end
    end
  end

  // memory word counts only if a valid word came while the memory was there
  wire               mem_word_ok;
  assign mem_word_ok = mem_present & (got_mem_ff | loader_strap_valid);

  always @* begin
    nxt_state   = state_ff;
    nxt_ready   = ready_ff;
    nxt_cnt     = cnt_ff;
    nxt_active  = active_ff;
    nxt_got_mem = got_mem_ff;
    nxt_start   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (capture_ff) begin
          nxt_active  = pin_word;                  // see RULE8
          nxt_got_mem = 1'b0;
          nxt_start   = 1'b1;
          nxt_state   = ST_LOAD;
          nxt_ready   = 1'b0;
        end else if (!full_power_state) begin
          nxt_ready = 1'b0;                        // see RULE5
          nxt_state = ST_SLEEP;
        end else if (restart) begin
          nxt_got_mem = 1'b0;
          nxt_start   = 1'b1;
          nxt_ready   = 1'b0;                      // see RULE3 RULE4
          nxt_state   = ST_LOAD;
        end
      end
      // restarts here are ignored; the loader is already running
      ST_LOAD: begin
        if (loader_strap_valid && mem_present) begin
          nxt_active  = loader_strap_data;         // see RULE7 RULE8
          nxt_got_mem = 1'b1;
        end
        if (loader_done) begin
          // erased or missing memory falls back to the last latched word
          if (!mem_word_ok)
            nxt_active = latched_ff;               // see RULE10
          // ready rises a cycle later, after straps have landed
          nxt_state = ST_WAKE;                     // see RULE2 RULE23
          nxt_cnt   = {CNT_W{1'b0}};
        end
      end
      // restarts while asleep are ignored
      ST_SLEEP: begin
        if (full_power_state) begin
          nxt_state = ST_WAKE;
          nxt_cnt   = SETTLE_CYC[CNT_W-1:0];
        end
      end
      ST_WAKE: begin
        if (!full_power_state) begin
          nxt_state = ST_SLEEP;                    // see RULE5
        end else if (restart) begin
          // a stale memory flag must not vouch for the next load
          nxt_got_mem = 1'b0;
          nxt_start = 1'b1;
          nxt_state = ST_LOAD;
        end else if (cnt_ff != {CNT_W{1'b0}}) begin
          nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (pll_locked) begin
          nxt_ready = 1'b1;                        // see RULE2 RULE6
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // control state and settle counter
  always @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= {CNT_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // active soft strap word; pin word lands at capture
  always @(posedge ref_clk) begin
    if (rst) begin
      active_ff  <= {STRAP_W{1'b0}};
      got_mem_ff <= 1'b0;
    end else begin
      active_ff  <= nxt_active;
      got_mem_ff <= nxt_got_mem;
    end
  end

  // ready level and its one-cycle companions
  always @(posedge ref_clk) begin
    if (rst) begin
      ready_ff        <= 1'b0;
      loader_start_ff <= 1'b0;
      ready_rise_ff   <= 1'b0;
    end else begin
      ready_ff        <= nxt_ready;
      loader_start_ff <= nxt_start;
      // event pulse lines up with the first cycle ready reads high
      ready_rise_ff   <= nxt_ready & ~ready_ff;    // see RULE22
    end
  end

  // host may only touch a few registers while this is low
  assign pmc_ready   = ready_ff;                   // see RULE1 RULE21
  assign hwc_ready   = ready_ff;                   // see RULE1
  assign loader_busy = (state_ff == ST_LOAD);

  // indicator register defaults
  assign indicator_enable_bits   = active_ff[`SLRS_IND_EN_MSB:`SLRS_IND_EN_LSB];   // see RULE12
  assign indicator_function_bits = active_ff[`SLRS_IND_FUN_MSB:`SLRS_IND_FUN_LSB]; // see RULE13

  // host bus port control defaults
  assign addr_strobe_qualify     = active_ff[`SLRS_QUAL_BIT];     // see RULE14
  assign access_style            = active_ff[`SLRS_STYLE_BIT];    // see RULE15
  assign select_polarity         = active_ff[`SLRS_SEL_POL_BIT];  // see RULE16
  assign read_polarity           = active_ff[`SLRS_RD_POL_BIT];   // see RULE17
  assign write_polarity          = active_ff[`SLRS_WR_POL_BIT];   // see RULE18
  assign addr_strobe_polarity    = active_ff[`SLRS_AS_POL_BIT];   // see RULE19

  // timestamp unit default
  assign timestamp_enable        = active_ff[`SLRS_TS_EN_BIT];    // see RULE20
endmodule

// file: tb/slrs_top_asserts.sv
// Purpose: port assertions for slrs_top
// Assumes: rst synchronous, active high
// Notes:   straps land an edge after release, so the hard check skips two edges
`timescale 1ns/10ps
module slrs_top_asserts #(
  parameter HARD_W = 4
) (
  // clock, reset
  input wire              ref_clk,
  input wire              rst,
  // watched ports
  input wire              reload_cmd,
  input wire              mac_reset_req,
  input wire              full_power_state,
  input wire              pll_locked,
  input wire              loader_busy,
  input wire              pmc_ready,
  input wire              hwc_ready,
  input wire              ready_rise_ff,
  input wire [HARD_W-1:0] hard_strap_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_SAME: assert property (pmc_ready == hwc_ready) else $error("ready copies differ");
  AST_BUSY: assert property (loader_busy |-> !pmc_ready) else $error("ready in load");
  AST_RELOAD: assert property (
    reload_cmd && pmc_ready |=> !pmc_ready && loader_busy) else $error("reload kept ready");
  AST_MAC: assert property (
    mac_reset_req && pmc_ready |=> !pmc_ready && loader_busy) else $error("mac kept ready");
  AST_SLEEP: assert property (
    !full_power_state && !$past(full_power_state) |-> !pmc_ready) else $error("ready in sleep");
  AST_RISE: assert property (
    $rose(pmc_ready) |-> $past(pll_locked) && $past(full_power_state) && !$past(loader_busy))
    else $error("ready rose early");
  AST_PULSE: assert property (
    $rose(pmc_ready) |-> ready_rise_ff ##1 !ready_rise_ff) else $error("bad ready event");
  AST_HARD: assert property (
    !$past(rst) && !$past(rst, 2) |-> $stable(hard_strap_ff)) else $error("hard strap moved");
endmodule
bind slrs_top slrs_top_asserts #(.HARD_W(HARD_W)) slrs_top_asserts_i (.*);

// file: tb/slrs_loader_model.sv
// Purpose: behavioural serial memory loader facing slrs_top
// Assumes: loader_start_ff is a one-cycle pulse
// Notes:   data inverts outside the valid cycle so a stale word never passes
`timescale 1ns/10ps
module slrs_loader_model (
  // bench knobs and loader handshake
  input  wire        ref_clk,
  input  wire [3:0]  dly,
  input  wire [15:0] word,
  input  wire        mem_present,
  input  wire        loader_start_ff,
  output reg         loader_strap_valid = 1'b0,
  output reg         loader_done = 1'b0,
  output reg  [15:0] loader_strap_data = 16'h0000
);
  reg [4:0] cnt_ff = 5'h00;
  always @(posedge ref_clk) begin
    cnt_ff <= loader_start_ff ? {1'b0, dly} + 5'h02 : cnt_ff - {4'h0, cnt_ff != 5'h00};
    loader_strap_valid <= cnt_ff == 5'h02 && mem_present;
    loader_strap_data <= cnt_ff == 5'h02 ? word : ~loader_strap_data;
    loader_done <= cnt_ff == 5'h01;
  end
endmodule

// file: tb/strap_latch_and_ready_status_test.sv
// Purpose: self-checking bench for strap latch and ready status
// Assumes: pll settle cut to 10 cycles to keep the run short
// Notes:   expected words come from pin levels, the 8'h47 tie-off defaults and loader words
`timescale 1ns/10ps
module strap_latch_and_ready_status_test;
  reg         ref_clk = 1'b0, rst = 1'b1, mem_present = 1'b0;
  reg         full_power_state = 1'b1, pll_locked = 1'b1;
  reg         digital_reset_req = 1'b0, mac_reset_req = 1'b0, reload_cmd = 1'b0;
  reg  [3:0]  hard_strap_pins = 4'h0, soft_strap_pins = 4'h0, dly = 4'h3;
  reg  [15:0] seed = 16'hE8BE, word = 16'h0000, latched = 16'h0000;
  integer     fails = 0, n_compared = 0, k;
  wire        loader_start_ff, loader_done, loader_strap_valid, pmc_ready, hwc_ready;
  wire        ready_rise_ff, loader_busy, addr_strobe_qualify, access_style, select_polarity;
  wire        read_polarity, write_polarity, addr_strobe_polarity, timestamp_enable;
  wire [2:0]  indicator_enable_bits, indicator_function_bits;
  wire [3:0]  hard_strap_ff;
  wire [15:0] loader_strap_data;
  wire [15:0] rdy = {14'h0, hwc_ready, pmc_ready};
  wire [15:0] got = {3'h0, timestamp_enable, addr_strobe_polarity, write_polarity, read_polarity,
    select_polarity, access_style, addr_strobe_qualify, indicator_function_bits, indicator_enable_bits};
  always #12.5 ref_clk = ~ref_clk;
  slrs_top #(.SETTLE_NS(250)) slrs_top_i (.*);
  slrs_loader_model slrs_loader_model_i (.*);
  function [15:0] lfsr_step(input [15:0] s);
    lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [15:0] have, input [15:0] want);
    n_compared = n_compared + 1;
    if (have !== want) begin
      fails = fails + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, have, want);
    end
  endtask
  // bounded, so a loader that never finishes shows as a mismatch
  task wait_ready;
    repeat (300) if (pmc_ready !== 1'b1) @(negedge ref_clk);
    chk(rdy, 16'h0003);
  endtask
  task pin_reset;
    seed = lfsr_step(seed);
    {soft_strap_pins, hard_strap_pins} = seed[7:0];
    rst = 1'b1;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    wait_ready;
    latched = {4'h0, soft_strap_pins, 8'h47};
    chk(got & 16'h00FF, latched & 16'h00FF);
    chk(got >> 8, latched >> 8);
    chk({12'h0, hard_strap_ff}, {12'h0, hard_strap_pins});
    $display("pin reset test done");
  endtask
  task results;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    pin_reset;
    for (k = 0; k < 3; k = k + 1) begin
      seed = lfsr_step(seed);
      {dly, word} = {seed[11:8], seed};
      soft_strap_pins = ~soft_strap_pins;
      mem_present = k < 2;
      {digital_reset_req, mac_reset_req, reload_cmd} = 3'h1 << k;
      @(negedge ref_clk);
      {digital_reset_req, mac_reset_req, reload_cmd} = 3'h0;
      chk(rdy, 16'h0000);
      wait_ready;
      chk(got, k < 2 ? {3'h0, word[12:0]} : latched);
      $display("restart test %0d done", k);
    end
    {full_power_state, pll_locked} = 2'h0;
    repeat (30) @(negedge ref_clk);
    chk(rdy, 16'h0000);
    full_power_state = 1'b1;
    repeat (30) @(negedge ref_clk);
    chk(rdy, 16'h0000);
    pll_locked = 1'b1;
    wait_ready;
    chk(got, latched);
    $display("sleep test done");
    pin_reset;
    results;
  end
  initial begin
    #(5000 * 25) fails = fails + 1;
    results;
  end
endmodule
